// [design/adc_ctrl_pkg.sv]
// package: register map, field positions and reset values of the converter control block
package adc_ctrl_pkg;
	localparam logic [2:0] ADDR_CTRL_START   = 3'h0;
	localparam logic [2:0] ADDR_SOURCE_CLOCK = 3'h1;
	localparam logic [2:0] ADDR_AMP_REF      = 3'h2;
	localparam logic [2:0] ADDR_BANDGAP      = 3'h3;
	localparam logic [2:0] ADDR_RESULT_LOW   = 3'h4;
	localparam logic [2:0] ADDR_RESULT_HIGH  = 3'h5;

	localparam int START_BIT    = 7;
	localparam int BUSY_BIT     = 6;
	localparam int ENABLE_BIT   = 5;
	localparam int ALIGN_BIT    = 4;
	localparam int AMP_EN_BIT   = 7;
	localparam int AMP_IN_BIT   = 4;
	localparam int BANDGAP_BIT  = 0;

	localparam logic [7:0] CTRL_START_RST  = 8'h00;
	localparam logic [7:0] SOURCE_CLK_RST  = 8'h00;
	localparam logic [7:0] AMP_REF_RST     = 8'h00;
	localparam logic [7:0] BANDGAP_RST     = 8'h00;
	localparam logic [7:0] CTRL_START_MASK = 8'hbf;
	localparam logic [7:0] SOURCE_CLK_MASK = 8'hf7;
	localparam logic [7:0] AMP_REF_MASK    = 8'h9f;
	localparam logic [7:0] BANDGAP_MASK    = 8'h01;

	typedef enum logic [2:0] {
		SRC_EXTERNAL,
		SRC_SUPPLY,
		SRC_SUPPLY_HALF,
		SRC_SUPPLY_QUARTER,
		SRC_AMP,
		SRC_AMP_HALF,
		SRC_AMP_QUARTER,
		SRC_GROUND
	} input_source_t;

	typedef enum logic [1:0] {
		REF_SUPPLY,
		REF_EXTERNAL_PIN,
		REF_AMP
	} reference_t;

	localparam logic [6:0] DIV_MAX = 7'h7f;
endpackage

// [design/conv_clock_divider.sv]
// power-of-two divider producing the conversion clock enable
`timescale 1ns/1ps
`default_nettype none
module conv_clock_divider #(
	parameter int WIDTH = 7
) (
	input  wire logic       clock_i,
	input  wire logic       rst_n_i,
	input  wire logic       run_i,
	input  wire logic [2:0] sel_i,
	output logic            tick_o
);
	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic             tick;
	} div_state_t;

	div_state_t state_r;
	div_state_t state_nxt;
	logic [WIDTH-1:0] limit;

	always_comb begin
		limit = WIDTH'((8'h01 << sel_i) - 8'h01);
		state_nxt = state_r;
		state_nxt.tick = 1'b0;
		if (!run_i) begin
			state_nxt.count = '0;
		end else if (state_r.count >= limit) begin
			state_nxt.count = '0;
			state_nxt.tick = 1'b1;
		end else begin
			state_nxt.count = state_r.count + WIDTH'(1);
		end
	end

	always_ff @(posedge clock_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign tick_o = state_r.tick;
endmodule
`default_nettype wire

// [design/analog_route_decode.sv]
// decodes source, channel and reference fields into analog switch controls
`timescale 1ns/1ps
`default_nettype none
module analog_route_decode (
	input  wire logic [3:0]  source_i,
	input  wire logic [3:0]  channel_i,
	input  wire logic        amp_input_i,
	input  wire logic [1:0]  ref_sel_i,
	output logic             ext_channel_on_o,
	output logic [15:0]      channel_onehot_o,
	output logic [2:0]       internal_source_o,
	output logic             amp_ref_pin_on_o,
	output logic             amp_bandgap_on_o,
	output logic [1:0]       reference_o,
	output logic             ext_ref_pin_on_o
);
	adc_ctrl_pkg::input_source_t src;
	adc_ctrl_pkg::reference_t    refs;

	always_comb begin
		case (source_i) // R8 R9
			4'h0, 4'h4, 4'hc, 4'hd, 4'he, 4'hf: src = adc_ctrl_pkg::SRC_EXTERNAL;
			4'h1: src = adc_ctrl_pkg::SRC_SUPPLY;
			4'h2: src = adc_ctrl_pkg::SRC_SUPPLY_HALF;
			4'h3: src = adc_ctrl_pkg::SRC_SUPPLY_QUARTER;
			4'h5: src = adc_ctrl_pkg::SRC_AMP;
			4'h6: src = adc_ctrl_pkg::SRC_AMP_HALF;
			4'h7: src = adc_ctrl_pkg::SRC_AMP_QUARTER;
			default: src = adc_ctrl_pkg::SRC_GROUND;
		endcase
		case (ref_sel_i) // R16
			2'h0: refs = adc_ctrl_pkg::REF_SUPPLY;
			2'h1: refs = adc_ctrl_pkg::REF_EXTERNAL_PIN;
			default: refs = adc_ctrl_pkg::REF_AMP;
		endcase
	end

	// reserved channel codes open all 16 channel switches rather than alias a pin; ext_channel_on_o still follows the source
	assign ext_channel_on_o  = (src == adc_ctrl_pkg::SRC_EXTERNAL); // R10
	assign channel_onehot_o  = (ext_channel_on_o && (channel_i != 4'ha) && (channel_i != 4'hb))
		? (16'h0001 << channel_i) : 16'h0000; // R6 R10
	assign internal_source_o = src;
	assign amp_ref_pin_on_o  = !amp_input_i; // R14
	assign amp_bandgap_on_o  = amp_input_i; // R14
	assign reference_o       = refs;
	assign ext_ref_pin_on_o  = (refs == adc_ctrl_pkg::REF_EXTERNAL_PIN); // R16
endmodule
`default_nettype wire

// [design/adc_control_register_block.sv]
// top: registers, start sequencing and result formatting of the 12-bit converter
// Summary of operation
// R1 - start bit high then low starts one conversion
// R2 - busy bit set from start until the conversion completes
// R3 - enable bit powers the converter; low switches it off
// R4 - result bytes stay unchanged while converter is disabled
// R5 - alignment bit selects 11:4/3:0 or 11:8/7:0 result layout
// R6 - channel field picks inputs 0 to 9 and 12 to 15
// R7 - software never writes reserved channel codes 1010 or 1011
// R8 - source codes 0000, 0100, 11xx external; 0001-0011 supply fractions
// R9 - source codes 0101-0111 amplifier fractions; 10xx ground
// R10 - internal source disconnects the external channel regardless of channel field
// R11 - unimplemented control bits read as zero
// R12 - clock field divides system clock by two to the code
// R13 - software enables amplifier when its output is used
// R14 - amplifier input bit picks reference pin or bandgap, exclusive
// R15 - software enables bandgap when it feeds the amplifier
// R16 - reference field picks supply, external pin or amplifier
// R17 - gain field selects gains 1, 1.667, 2.5, 3.333
// R18 - software enables bandgap and waits before using it
// R19 - pin used as converter input drops its other function and pull-up
// R20 - result bits unused by alignment read as zero
// R21 - completion raises the converter interrupt request flag
// R22 - start strobe to core on falling start edge; result loaded on done
// R23 - all control bits reset to zero
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_block #(
	parameter int DIV_WIDTH = 7,
	parameter int PINS      = 16
) (
	input  wire logic             clock_i,
	input  wire logic             rstn_i,
	input  wire logic [2:0]       addr_i,
	input  wire logic [7:0]       wdata_i,
	input  wire logic             wr_i,
	input  wire logic             rd_i,
	output logic [7:0]            rdata_o,
	input  wire logic             core_done_i,
	input  wire logic [11:0]      core_result_i,
	input  wire logic [PINS-1:0]  pin_analog_sel_i,
	output logic                  core_start_o,
	output logic                  core_power_o,
	output logic                  conv_clock_tick_o,
	output logic                  ext_channel_on_o,
	output logic [15:0]           channel_onehot_o,
	output logic [2:0]            internal_source_o,
	output logic                  gain_amp_power_o,
	output logic                  amp_ref_pin_on_o,
	output logic                  amp_bandgap_on_o,
	output logic [1:0]            gain_amp_gain_select_o,
	output logic [1:0]            reference_o,
	output logic                  ext_ref_pin_on_o,
	output logic                  bandgap_power_o,
	output logic                  conv_irq_flag_o,
	output logic [PINS-1:0]       pin_digital_off_o,
	output logic [PINS-1:0]       pin_pullup_off_o
);
	typedef struct packed {
		logic [7:0]  ctrl;
		logic [7:0]  source_clk;
		logic [7:0]  amp_ref;
		logic [7:0]  bandgap;
		logic        busy;
		logic        start_strobe;
		logic        irq;
		logic [11:0] result;
		logic        result_align;
		logic [7:0]  rdata;
		logic [PINS-1:0] pin_off;
	} blk_state_t;

	blk_state_t state_r;
	blk_state_t state_nxt;
	logic       rst_sync1_r;
	logic       rst_sync2_r;
	logic       rst_n;

	// reset released through two flops; assertion stays asynchronous
	always_ff @(posedge clock_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end
	assign rst_n = rst_sync2_r;

	function automatic logic [15:0] format_result(input logic [11:0] d, input logic align);
		if (align) begin
			format_result = {4'h0, d}; // R5 R20
		end else begin
			format_result = {d, 4'h0}; // R5 R20
		end
	endfunction

	logic [15:0] result_view;
	logic        start_fall;
	logic        start_new;

	assign result_view = format_result(state_r.result, state_r.result_align);
	assign start_new   = wr_i && (addr_i == adc_ctrl_pkg::ADDR_CTRL_START);
	// a start dropped in one write is the documented 0-1-0 sequence's end
	assign start_fall  = start_new && state_r.ctrl[adc_ctrl_pkg::START_BIT]
		&& !wdata_i[adc_ctrl_pkg::START_BIT]; // R1

	always_comb begin
		state_nxt = state_r;
		state_nxt.start_strobe = 1'b0;
		state_nxt.irq = 1'b0;
		if (wr_i) begin
			case (addr_i)
				adc_ctrl_pkg::ADDR_CTRL_START:
					state_nxt.ctrl = wdata_i & adc_ctrl_pkg::CTRL_START_MASK;
				adc_ctrl_pkg::ADDR_SOURCE_CLOCK:
					state_nxt.source_clk = wdata_i & adc_ctrl_pkg::SOURCE_CLK_MASK; // R11
				adc_ctrl_pkg::ADDR_AMP_REF:
					state_nxt.amp_ref = wdata_i & adc_ctrl_pkg::AMP_REF_MASK; // R11
				adc_ctrl_pkg::ADDR_BANDGAP:
					state_nxt.bandgap = wdata_i & adc_ctrl_pkg::BANDGAP_MASK; // R11
				default: begin
				end
			endcase
		end
		// alignment applies to reads at once; stored data are not reshuffled
		state_nxt.result_align = state_nxt.ctrl[adc_ctrl_pkg::ALIGN_BIT]; // R5
		if (!state_nxt.ctrl[adc_ctrl_pkg::ENABLE_BIT]) begin
			state_nxt.busy = 1'b0; // R3
		end else if (state_r.busy && core_done_i && !state_r.start_strobe) begin
			state_nxt.busy = 1'b0; // R2
			state_nxt.irq = 1'b1; // R21
			state_nxt.result = core_result_i; // R22 R4
		end
		// a new start outranks a completion in the same cycle; none while switching off
		if (start_fall && state_r.ctrl[adc_ctrl_pkg::ENABLE_BIT]
			&& state_nxt.ctrl[adc_ctrl_pkg::ENABLE_BIT]) begin
			state_nxt.start_strobe = 1'b1; // R22
			state_nxt.busy = 1'b1; // R2
		end
		state_nxt.pin_off = pin_analog_sel_i; // R19
		state_nxt.rdata = 8'h00;
		if (rd_i) begin
			case (addr_i)
				adc_ctrl_pkg::ADDR_CTRL_START:
					state_nxt.rdata = {state_r.ctrl[7], state_r.busy, state_r.ctrl[5:0]};
				adc_ctrl_pkg::ADDR_SOURCE_CLOCK: state_nxt.rdata = state_r.source_clk;
				adc_ctrl_pkg::ADDR_AMP_REF:      state_nxt.rdata = state_r.amp_ref;
				adc_ctrl_pkg::ADDR_BANDGAP:      state_nxt.rdata = state_r.bandgap;
				adc_ctrl_pkg::ADDR_RESULT_LOW:   state_nxt.rdata = result_view[7:0]; // R20
				adc_ctrl_pkg::ADDR_RESULT_HIGH:  state_nxt.rdata = result_view[15:8]; // R20
				default: state_nxt.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= '0; // R23
		end else begin
			state_r <= state_nxt;
		end
	end

	conv_clock_divider #(
		.WIDTH(DIV_WIDTH)
	) u_div (
		.clock_i (clock_i),
		.rst_n_i (rst_n),
		.run_i   (state_r.ctrl[adc_ctrl_pkg::ENABLE_BIT]),
		.sel_i   (state_r.source_clk[2:0]), // R12
		.tick_o  (conv_clock_tick_o)
	);

	analog_route_decode u_route (
		.source_i          (state_r.source_clk[7:4]),
		.channel_i         (state_r.ctrl[3:0]),
		.amp_input_i       (state_r.amp_ref[adc_ctrl_pkg::AMP_IN_BIT]),
		.ref_sel_i         (state_r.amp_ref[3:2]),
		.ext_channel_on_o  (ext_channel_on_o),
		.channel_onehot_o  (channel_onehot_o),
		.internal_source_o (internal_source_o),
		.amp_ref_pin_on_o  (amp_ref_pin_on_o),
		.amp_bandgap_on_o  (amp_bandgap_on_o),
		.reference_o       (reference_o),
		.ext_ref_pin_on_o  (ext_ref_pin_on_o)
	);

	assign rdata_o                = state_r.rdata;
	assign core_start_o           = state_r.start_strobe;
	assign core_power_o           = state_r.ctrl[adc_ctrl_pkg::ENABLE_BIT]; // R3
	assign gain_amp_power_o       = state_r.amp_ref[adc_ctrl_pkg::AMP_EN_BIT];
	assign gain_amp_gain_select_o = state_r.amp_ref[1:0]; // R17
	assign bandgap_power_o        = state_r.bandgap[adc_ctrl_pkg::BANDGAP_BIT];
	assign conv_irq_flag_o        = state_r.irq; // R21
	assign pin_digital_off_o      = state_r.pin_off; // R19
	assign pin_pullup_off_o       = state_r.pin_off; // R19
endmodule
`default_nettype wire

// [sim/adc_core_model.sv]
// behavioural analog core: answers each start strobe after a set delay
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	input  wire logic        clock_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  delay_i,
	output logic             done_o,
	output logic [11:0]      result_o,
	output logic [11:0]      last_o
);
	logic [7:0] cnt = 8'h00;
	logic       run = 1'b0;
	initial begin
		done_o = 1'b0;
		result_o = 12'h000;
		last_o = 12'h000;
	end
	// result lines churn outside the done cycle so stale data never looks valid
	always @(posedge clock_i) begin
		done_o <= 1'b0;
		result_o <= ~result_o;
		if (start_i) begin
			run <= 1'b1;
			cnt <= delay_i;
		end else if (run && cnt == 8'h00) begin
			run <= 1'b0;
			done_o <= 1'b1;
			last_o = 12'($urandom_range(4095, 0));
			result_o <= last_o;
		end else if (run) begin
			cnt <= cnt - 8'h01;
		end
	end
endmodule
`default_nettype wire

// [sim/adc_control_register_block_monitor.sv]
// checker: port-level properties of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_block_monitor (
	input  wire logic        clock_i,
	input  wire logic        rstn_i,
	input  wire logic [2:0]  addr_i,
	input  wire logic [7:0]  wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [7:0]  rdata_o,
	input  wire logic        core_done_i,
	input  wire logic        core_start_o,
	input  wire logic        core_power_o,
	input  wire logic        ext_channel_on_o,
	input  wire logic [15:0] channel_onehot_o,
	input  wire logic [2:0]  internal_source_o,
	input  wire logic        amp_ref_pin_on_o,
	input  wire logic        amp_bandgap_on_o,
	input  wire logic        conv_irq_flag_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_start_cause: assert property (core_start_o |-> $past(wr_i && addr_i == 3'h0 && !wdata_i[7]))
		else $error("start strobe without a start-clearing write");
	a_start_single: assert property (core_start_o |=> !core_start_o)
		else $error("start strobe longer than one cycle");
	a_power_follow: assert property ((wr_i && addr_i == 3'h0) ##1 !(wr_i && addr_i == 3'h0)
		|=> core_power_o == $past(wdata_i[5], 2))
		else $error("converter power does not follow enable bit");
	a_irq_cause: assert property (conv_irq_flag_o |-> $past(core_done_i))
		else $error("completion flag without core done");
	a_irq_single: assert property (conv_irq_flag_o |=> !conv_irq_flag_o)
		else $error("completion flag longer than one cycle");
	a_ext_exclusive: assert property (!ext_channel_on_o |-> channel_onehot_o == 16'h0000
		&& internal_source_o != 3'h0)
		else $error("external channel switch closed with internal source");
	a_amp_input_excl: assert property (amp_ref_pin_on_o != amp_bandgap_on_o)
		else $error("amplifier input switches not exclusive");
	a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
		else $error("read data outside the read answer cycle");
endmodule
bind adc_control_register_block adc_control_register_block_monitor u_mon (.clock_i(clock_i),
	.rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
	.rdata_o(rdata_o), .core_done_i(core_done_i), .core_start_o(core_start_o),
	.core_power_o(core_power_o), .ext_channel_on_o(ext_channel_on_o),
	.channel_onehot_o(channel_onehot_o), .internal_source_o(internal_source_o),
	.amp_ref_pin_on_o(amp_ref_pin_on_o), .amp_bandgap_on_o(amp_bandgap_on_o),
	.conv_irq_flag_o(conv_irq_flag_o));
`default_nettype wire

// [sim/adc_control_register_block_bench.sv]
// testbench: registers, conversions, routing, pins and clock divider
`timescale 1ns/1ps
`default_nettype none
module adc_control_register_block_bench;
	logic        clock_i = 1'b0;
	logic        rstn_i = 1'b0;
	logic [2:0]  addr_i = 3'h0;
	logic [7:0]  wdata_i = 8'h00;
	logic        wr_i = 1'b0;
	logic        rd_i = 1'b0;
	logic [15:0] pin_analog_sel_i = 16'h0000;
	logic [7:0]  delay = 8'h0c;
	logic [7:0]  rdata_o, rv, hi;
	logic [15:0] channel_onehot_o, pin_digital_off_o, pin_pullup_off_o;
	logic [11:0] core_result_i, last, saved;
	logic [2:0]  internal_source_o;
	logic [1:0]  gain_amp_gain_select_o, reference_o;
	logic        core_done_i, core_start_o, core_power_o, conv_clock_tick_o, ext_channel_on_o;
	logic        gain_amp_power_o, amp_ref_pin_on_o, amp_bandgap_on_o, ext_ref_pin_on_o;
	logic        bandgap_power_o, conv_irq_flag_o, al;
	logic [3:0]  ch, e;
	logic [5:0]  v;
	logic [7:0]  m [4] = '{8'h3f, 8'hf7, 8'h9f, 8'h01};
	int          mismatches = 0;
	int          samples_checked = 0;
	int          n, c;
	adc_control_register_block u_adc_control_register_block (.*);
	adc_core_model u_adc_core_model (.clock_i(clock_i), .start_i(core_start_o), .delay_i(delay),
		.done_o(core_done_i), .result_o(core_result_i), .last_o(last));
	always #25 clock_i = ~clock_i;
	task automatic check(logic [23:0] got, logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checked=%0d mismatches=%0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic wr(logic [2:0] a, logic [7:0] d);
		@(posedge clock_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clock_i);
		wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [2:0] a);
		@(posedge clock_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1;
		rv = rdata_o;
	endtask
	// the completion flag lasts one cycle, so it is polled every cycle
	task automatic wait_irq();
		for (int k = 0; k < 300; k++) begin
			if (conv_irq_flag_o === 1'b1) return;
			@(posedge clock_i);
			#1;
		end
		mismatches++;
		print_verdict();
	endtask
	function automatic logic [15:0] fmt(logic [11:0] d, logic a);
		return a ? {4'h0, d} : {d, 4'h0};
	endfunction
	function automatic logic [3:0] src(logic [3:0] s);
		casez (s)
			4'b0000, 4'b0100, 4'b11??: return 4'h8;
			4'b10??: return 4'h7;
			default: return {1'b0, s[2:0] - (s[2] ? 3'h1 : 3'h0)};
		endcase
	endfunction
	initial begin
		void'($urandom(97394));
		repeat (20) @(posedge clock_i);
		rstn_i <= 1'b1;
		repeat (3) @(posedge clock_i);
		for (int a = 0; a < 8; a++) begin
			if (a == 4 || a == 5) continue;
			rd(a[2:0]);
			check(rv, 0);
		end
		for (int a = 0; a < 4; a++) begin
			wr(a[2:0], a == 0 ? 8'h7f : 8'hff);
			rd(a[2:0]);
			check(rv, m[a]);
			wr(a[2:0], 8'h00);
		end
		for (int i = 0; i < 6; i++) begin
			al = i[0];
			delay <= 8'($urandom_range(30, 12));
			wr(3'h0, {3'b101, al, 4'h0});
			wr(3'h0, {3'b001, al, 4'h0});
			rd(3'h0);
			check(rv, {3'b011, al, 4'h0});
			wait_irq();
			rd(3'h5);
			hi = rv;
			rd(3'h4);
			check({hi, rv}, fmt(last, al));
			rd(3'h0);
			check(rv, {3'b001, al, 4'h0});
		end
		// start attempt while disabled: no conversion, stored result untouched
		wr(3'h0, 8'h80);
		wr(3'h0, 8'h00);
		check(core_power_o, 0);
		rd(3'h5);
		hi = rv;
		rd(3'h4);
		check({hi, rv}, fmt(last, 1'b0));
		rd(3'h0);
		check(rv, 0);
		// switch off mid-conversion: the late core answer must not reach the result bytes
		saved = last;
		wr(3'h0, 8'ha0);
		wr(3'h0, 8'h20);
		wr(3'h0, 8'h00);
		repeat (40) @(posedge clock_i);
		rd(3'h5);
		hi = rv;
		rd(3'h4);
		check({hi, rv}, fmt(saved, 1'b0));
		rd(3'h0);
		check(rv, 0);
		for (int s = 0; s < 16; s++) begin
			ch = 4'($urandom_range(15, 0));
			if (ch == 4'ha || ch == 4'hb) ch = 4'hc;
			e = src(s[3:0]);
			wr(3'h1, {s[3:0], 4'h0});
			wr(3'h0, {4'h0, ch});
			check({ext_channel_on_o, internal_source_o, channel_onehot_o},
				{e, e[3] ? 16'h0001 << ch : 16'h0000});
		end
		wr(3'h3, 8'h01);
		check(bandgap_power_o, 1);
		for (int k = 0; k < 64; k++) begin
			v = k[5:0];
			wr(3'h2, {v[5], 2'b00, v[4:0]});
			check({gain_amp_power_o, amp_bandgap_on_o, amp_ref_pin_on_o, reference_o,
				ext_ref_pin_on_o, gain_amp_gain_select_o}, {v[5], v[4], !v[4],
				v[3] ? 2'd2 : v[3:2], v[3:2] == 2'b01, v[1:0]});
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge clock_i);
			pin_analog_sel_i <= 16'($urandom);
			@(posedge clock_i);
			#1;
			check({pin_digital_off_o, pin_pullup_off_o}, {2{pin_analog_sel_i}});
		end
		wr(3'h0, 8'h20);
		for (int k = 0; k < 8; k++) begin
			c = k;
			wr(3'h1, 8'(c));
			repeat (2 << c) @(posedge clock_i);
			n = 0;
			repeat (8 << c) begin
				@(posedge clock_i);
				#1;
				n += int'(conv_clock_tick_o);
			end
			check(n, 8);
		end
		print_verdict();
	end
endmodule
`default_nettype wire
